/* rtl/irq_mode_if.sv */
`timescale 1ns/1ns
interface irq_mode_if;
  logic level_sel;
  logic event_p;
  logic pending;
  logic irq;
  modport ctrl (output level_sel, output event_p, output pending, input irq);
  modport shaper (input level_sel, input event_p, input pending, output irq);
endinterface // irq_mode_if

/* rtl/irq_shaper.sv */
// Purpose: shape one host interrupt as edge pulse or level
// Assumes: event_p is a one-cycle pulse on a new event
// Notes: edge output is registered, so one cycle late
`timescale 1ns/1ns
module irq_shaper
  import sockreg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  irq_mode_if.shaper m
);
  logic pulse_r;
  logic pulse_nxt;

  always_comb begin
    pulse_nxt = m.event_p;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_r <= 1'b0;
    end else begin
      pulse_r <= pulse_nxt;
    end
  end

  assign m.irq = m.level_sel ? m.pending : pulse_r;

  edge_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!m.level_sel && m.event_p) |=> m.irq) else $error("edge mode pulse missing");
  level_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    m.level_sel |-> m.irq == m.pending)
    else $error("level mode not following pending");
  edge_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!m.level_sel && !m.event_p) |=> (!m.irq || m.level_sel))
    else $error("edge mode held high");
endmodule // irq_shaper

/* rtl/socket_regs.sv */
// Purpose: socket global control and I/O window offset registers
// Assumes: host byte accesses arrive synchronous to clk_i
// Notes: status-change flags kept here for clear behaviour and the status-change interrupt
`timescale 1ns/1ns
`include "sockreg_defines.svh"
module socket_regs
  import sockreg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic global_reset_in_i,
  input wire logic reg_sel_i,
  input wire logic legacy_i,
  input wire logic [11:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic csc_rd_i,
  input wire logic csc_wr_i,
  input wire logic [7:0] csc_wdata_i,
  input wire logic [7:0] csc_event_i,
  input wire logic sw_cd_req_set_i,
  output logic sw_cd_req_o,
  output logic [7:0] status_change_reg_o,
  input wire logic card_a_event_i,
  input wire logic card_b_event_i,
  input wire logic card_a_pending_i,
  input wire logic card_b_pending_i,
  output logic irq_a_o,
  output logic irq_b_o,
  output logic irq_csc_o,
  input wire logic card_cycle_i,
  output logic card_out_en_o,
  output logic card_irq_accept_o,
  output logic [15:0] win0_offset_o,
  output logic [15:0] win1_offset_o
);
  logic [7:0] gctrl_r;
  logic [7:0] gctrl_nxt;
  logic [7:0] win_lo_r [2];
  logic [7:0] win_lo_nxt [2];
  logic [7:0] win_hi_r [2];
  logic [7:0] win_hi_nxt [2];
  logic [7:0] csc_r;
  logic [7:0] csc_nxt;
  logic swcd_r;
  logic swcd_nxt;
  logic [11:0] eff_addr;
  logic wr_g;
  logic wr_win [2][2];
  logic csc_new;
  logic any_rst;

  irq_mode_if ma();
  irq_mode_if mb();
  irq_mode_if mc();

  // legacy index maps to the same offsets by low byte
  assign eff_addr = legacy_i ? {4'h8, addr_i[7:0]} : addr_i;
  // shapers drop a half-sent pulse on either reset
  assign any_rst = rst_i || global_reset_in_i;
  assign wr_g = reg_sel_i && wr_i && (eff_addr == `GCTRL_OFS);

  always_comb begin
    wr_win[0][0] = reg_sel_i && wr_i && (eff_addr == `WIN0_LO_OFS);
    wr_win[0][1] = reg_sel_i && wr_i && (eff_addr == `WIN0_HI_OFS);
    wr_win[1][0] = reg_sel_i && wr_i && (eff_addr == `WIN1_LO_OFS);
    wr_win[1][1] = reg_sel_i && wr_i && (eff_addr == `WIN1_HI_OFS);
  end

  always_comb begin
    gctrl_nxt = gctrl_r;
    if (wr_g) begin
      gctrl_nxt = wdata_i & `GC_RW_MASK;
    end
    if (rst_i) begin
      gctrl_nxt = gctrl_r & 8'h07;
    end
  end

  always_ff @(posedge clk_i) begin
    if (global_reset_in_i) begin
      gctrl_r <= `GCTRL_RST;
    end else begin
      gctrl_r <= gctrl_nxt;
    end
  end

  genvar w;
  generate
    for (w = 0; w < 2; w++) begin : g_win
      always_comb begin
        win_lo_nxt[w] = win_lo_r[w];
        win_hi_nxt[w] = win_hi_r[w];
        if (wr_win[w][0]) begin
          win_lo_nxt[w] = wdata_i & `WIN_LO_MASK;
        end
        if (wr_win[w][1]) begin
          win_hi_nxt[w] = wdata_i;
        end
      end
      always_ff @(posedge clk_i) begin
        if (rst_i || global_reset_in_i) begin
          win_lo_r[w] <= `WIN_RST;
          win_hi_r[w] <= `WIN_RST;
        end else begin
          win_lo_r[w] <= win_lo_nxt[w];
          win_hi_r[w] <= win_hi_nxt[w];
        end
      end
    end
  endgenerate

  assign win0_offset_o = {win_hi_r[0], win_lo_r[0]};
  assign win1_offset_o = {win_hi_r[1], win_lo_r[1]};

  // new events always win over a clear in the same cycle
  always_comb begin
    csc_nxt = csc_r;
    swcd_nxt = swcd_r | sw_cd_req_set_i;
    // clear by read or by write-one
    if (gctrl_r[`GC_FCLR_BIT]) begin
      if (csc_wr_i) begin
        csc_nxt = csc_r & ~csc_wdata_i;
        if (csc_wdata_i[`CD_FLAG_BIT]) begin
          swcd_nxt = sw_cd_req_set_i;
        end
      end
    end else if (csc_rd_i) begin
      csc_nxt = 8'h00;
    end
    csc_nxt = csc_nxt | csc_event_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || global_reset_in_i) begin
      csc_r <= 8'h00;
      swcd_r <= 1'b0;
    end else begin
      csc_r <= csc_nxt;
      swcd_r <= swcd_nxt;
    end
  end

  assign status_change_reg_o = csc_r;
  assign sw_cd_req_o = swcd_r;
  assign csc_new = |(csc_event_i & ~csc_r);

  assign ma.level_sel = gctrl_r[`GC_ALVL_BIT];
  assign ma.event_p = card_a_event_i;
  assign ma.pending = card_a_pending_i;
  assign mb.level_sel = gctrl_r[`GC_BLVL_BIT];
  assign mb.event_p = card_b_event_i;
  assign mb.pending = card_b_pending_i;
  assign mc.level_sel = gctrl_r[`GC_CSCLVL_BIT];
  assign mc.event_p = csc_new;
  assign mc.pending = |csc_r;

  irq_shaper u_irq_a (.clk_i(clk_i), .rst_i(any_rst), .m(ma.shaper));
  irq_shaper u_irq_b (.clk_i(clk_i), .rst_i(any_rst), .m(mb.shaper));
  irq_shaper u_irq_c (.clk_i(clk_i), .rst_i(any_rst), .m(mc.shaper));

  assign irq_a_o = ma.irq;
  assign irq_b_o = mb.irq;
  assign irq_csc_o = mc.irq;

  // in power-down, outputs driven only in active cycle
  assign card_out_en_o = !gctrl_r[`GC_PWRDN_BIT] || card_cycle_i;
  assign card_irq_accept_o = 1'b1;

  // read mux, registered; unmapped reads zero
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_sel_i && rd_i) begin
      unique case (eff_addr)
        `GCTRL_OFS: rdata_nxt = gctrl_r & `GC_RW_MASK;
        `WIN0_LO_OFS: rdata_nxt = win_lo_r[0];
        `WIN0_HI_OFS: rdata_nxt = win_hi_r[0];
        `WIN1_LO_OFS: rdata_nxt = win_lo_r[1];
        `WIN1_HI_OFS: rdata_nxt = win_hi_r[1];
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign rdata_o = rdata_r;

  rsvd_zero_a: assert property (@(posedge clk_i) disable iff (global_reset_in_i) gctrl_r[7:5] == 3'h0)
    else $error("reserved bits set");
  mode_b_a: assert property (@(posedge clk_i) disable iff (rst_i || global_reset_in_i)
    wr_g |=> gctrl_r[`GC_BLVL_BIT] == $past(wdata_i[4])) else $error("card B mode not stored");
  mode_a_a: assert property (@(posedge clk_i) disable iff (global_reset_in_i)
    (gctrl_r[`GC_ALVL_BIT] && card_a_pending_i) |-> irq_a_o) else $error("card A level lost");
  read_clear_a: assert property (@(posedge clk_i) disable iff (rst_i || global_reset_in_i)
    (!gctrl_r[`GC_FCLR_BIT] && csc_rd_i && csc_event_i == 8'h00) |=> csc_r == 8'h00)
    else $error("read clear failed");
  csc_level_a: assert property (@(posedge clk_i) disable iff (global_reset_in_i)
    (gctrl_r[`GC_CSCLVL_BIT] && |csc_r) |-> irq_csc_o) else $error("csc level lost");
  pwrdn_hiz_a: assert property (@(posedge clk_i)
    (gctrl_r[`GC_PWRDN_BIT] && !card_cycle_i) |-> !card_out_en_o) else $error("driven in power-down");
  ctrl_keep_a: assert property (@(posedge clk_i)
    (rst_i && !global_reset_in_i) |=> gctrl_r[2:0] == $past(gctrl_r[2:0])) else $error("bits 2-0 lost");
  lo_bit0_a: assert property (@(posedge clk_i) disable iff (rst_i || global_reset_in_i)
    win_lo_r[0][0] == 1'h0 && win_lo_r[1][0] == 1'h0)
    else $error("window low bit 0 set");
  hi_write_a: assert property (@(posedge clk_i) disable iff (rst_i || global_reset_in_i)
    wr_win[1][1] |=> win_hi_r[1] == $past(wdata_i)) else $error("high byte not stored");
  swcd_clr_a: assert property (@(posedge clk_i) disable iff (rst_i || global_reset_in_i)
    (gctrl_r[`GC_FCLR_BIT] && csc_wr_i && csc_wdata_i[3] && !sw_cd_req_set_i) |=> !sw_cd_req_o)
    else $error("sw request not cleared");

  // control register stores, resets and reads
  gctrl_store_a: assert property (@(posedge clk_i) disable iff (rst_i || global_reset_in_i)
    wr_g |=> gctrl_r == ($past(wdata_i) & `GC_RW_MASK))
    else $error("control write not stored");
  mode_a_store_a: assert property (@(posedge clk_i) disable iff (rst_i || global_reset_in_i)
    wr_g |=> gctrl_r[`GC_ALVL_BIT] == $past(wdata_i[3]))
    else $error("card A mode not stored");
  fclr_store_a: assert property (@(posedge clk_i) disable iff (rst_i || global_reset_in_i)
    wr_g |=> gctrl_r[`GC_FCLR_BIT] == $past(wdata_i[2]))
    else $error("clear mode not stored");
  csc_mode_store_a: assert property (@(posedge clk_i) disable iff (rst_i || global_reset_in_i)
    wr_g |=> gctrl_r[`GC_CSCLVL_BIT] == $past(wdata_i[1]))
    else $error("status-change mode not stored");
  pwrdn_store_a: assert property (@(posedge clk_i) disable iff (rst_i || global_reset_in_i)
    wr_g |=> gctrl_r[`GC_PWRDN_BIT] == $past(wdata_i[0]))
    else $error("power-down bit not stored");
  upper_rst_a: assert property (@(posedge clk_i)
    (rst_i && !global_reset_in_i) |=> gctrl_r[4:3] == 2'h0)
    else $error("mode bits kept over socket reset");
  gctrl_init_a: assert property (@(posedge clk_i)
    global_reset_in_i |=> gctrl_r == `GCTRL_RST)
    else $error("control not reset");
  legacy_map_a: assert property (@(posedge clk_i) disable iff (rst_i || global_reset_in_i)
    (reg_sel_i && wr_i && legacy_i && addr_i[7:0] == `GCTRL_IDX) |=> gctrl_r == ($past(wdata_i) & `GC_RW_MASK))
    else $error("legacy index write lost");
  gctrl_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (reg_sel_i && rd_i && eff_addr == `GCTRL_OFS) |=> rdata_o == ($past(gctrl_r) & `GC_RW_MASK))
    else $error("control read wrong");

  // window offset bytes
  lo0_write_a: assert property (@(posedge clk_i) disable iff (rst_i || global_reset_in_i)
    wr_win[0][0] |=> win_lo_r[0] == ($past(wdata_i) & `WIN_LO_MASK))
    else $error("window 0 low byte not stored");
  lo1_write_a: assert property (@(posedge clk_i) disable iff (rst_i || global_reset_in_i)
    wr_win[1][0] |=> win_lo_r[1] == ($past(wdata_i) & `WIN_LO_MASK))
    else $error("window 1 low byte not stored");
  hi0_write_a: assert property (@(posedge clk_i) disable iff (rst_i || global_reset_in_i)
    wr_win[0][1] |=> win_hi_r[0] == $past(wdata_i))
    else $error("window 0 high byte not stored");
  win_clear_a: assert property (@(posedge clk_i)
    (rst_i || global_reset_in_i) |=> win_hi_r[0] == `WIN_RST && win_hi_r[1] == `WIN_RST)
    else $error("high bytes not reset");
  win_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (reg_sel_i && rd_i && eff_addr == `WIN1_HI_OFS) |=> rdata_o == $past(win_hi_r[1]))
    else $error("window 1 high read wrong");

  // status-change flags and their interrupt
  wb_read_keep_a: assert property (@(posedge clk_i) disable iff (rst_i || global_reset_in_i)
    (gctrl_r[`GC_FCLR_BIT] && csc_rd_i && !csc_wr_i) |=> csc_r == ($past(csc_r) | $past(csc_event_i)))
    else $error("read cleared in write-back mode");
  event_wins_a: assert property (@(posedge clk_i) disable iff (rst_i || global_reset_in_i)
    (csc_event_i != 8'h00) |=> (csc_r & $past(csc_event_i)) == $past(csc_event_i))
    else $error("event lost to clear");
  csc_edge_a: assert property (@(posedge clk_i) disable iff (rst_i || global_reset_in_i)
    (!gctrl_r[`GC_CSCLVL_BIT] && csc_new) |=> irq_csc_o)
    else $error("csc edge pulse missing");
  swcd_keep_a: assert property (@(posedge clk_i) disable iff (rst_i || global_reset_in_i)
    (gctrl_r[`GC_FCLR_BIT] && csc_wr_i && !csc_wdata_i[`CD_FLAG_BIT])
    |=> sw_cd_req_o == ($past(sw_cd_req_o) || $past(sw_cd_req_set_i)))
    else $error("sw request dropped");

  // power-down still drives card cycles and keeps interrupts alive
  wake_drive_a: assert property (@(posedge clk_i) disable iff (global_reset_in_i)
    card_cycle_i |-> card_out_en_o)
    else $error("card cycle not driven");
  pwrdn_irq_a: assert property (@(posedge clk_i) disable iff (rst_i || global_reset_in_i)
    (gctrl_r[`GC_PWRDN_BIT] && gctrl_r[`GC_ALVL_BIT] && gctrl_r[`GC_BLVL_BIT] && card_a_pending_i
    && card_b_pending_i) |-> (irq_a_o && irq_b_o))
    else $error("card interrupt lost in power-down");
  pwrdn_csc_a: assert property (@(posedge clk_i) disable iff (rst_i || global_reset_in_i)
    (gctrl_r[`GC_PWRDN_BIT] && csc_new) |=> irq_csc_o)
    else $error("csc interrupt lost in power-down");
endmodule // socket_regs

/* rtl/sockreg_defines.svh */
// Purpose: constants for the socket control and I/O offset register bank
// Assumes: byte-wide register access, 12-bit socket-base offset
// Notes: legacy index is the low byte of the socket-base offset
// Overview of operation
// - global control bits 7-5 read zero, writes to them ignored.
// - bit 4 selects card B host interrupt edge (0) or level (1).
// - bit 3 selects card A host interrupt edge (0) or level (1).
// - bit 2 selects status-change clear: read clears (0) or write-one (1).
// - bit 1 selects status-change host interrupt edge (0) or level (1).
// - bit 0 power-down: card outputs undriven except during an active card cycle.
// - in power-down card interrupts still accepted; only a card access wakes interface.
// - control bits 2-0 cleared only by global reset.
// - global control at offset 81Eh, legacy index 1Eh, resets to 00h.
// - window low offset byte holds bits 7-0; bit 0 always reads zero.
// - window high offset byte holds bits 15-8, fully read/write, resets zero.
// - window 0 at 836h/837h, window 1 at 838h/839h.
// - write-one clear of card-detect flag also clears software card-detect request.
`ifndef SOCKREG_DEFINES_SVH
`define SOCKREG_DEFINES_SVH
`define GCTRL_OFS 12'h81E
`define GCTRL_IDX 8'h1E
`define WIN0_LO_OFS 12'h836
`define WIN0_HI_OFS 12'h837
`define WIN1_LO_OFS 12'h838
`define WIN1_HI_OFS 12'h839
`define GCTRL_RST 8'h00
`define WIN_RST 8'h00
`define GC_PWRDN_BIT 0
`define GC_CSCLVL_BIT 1
`define GC_FCLR_BIT 2
`define GC_ALVL_BIT 3
`define GC_BLVL_BIT 4
`define GC_RW_MASK 8'h1F
`define WIN_LO_MASK 8'hFE
`define CD_FLAG_BIT 3
`endif

/* rtl/sockreg_pkg.sv */
package sockreg_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {IRQ_A, IRQ_B, IRQ_CSC} irq_src_e;
endpackage

/* sim/host_model.sv */
// Purpose: host-side register bus driver for the socket register bank
// Assumes: strobes launched at the falling edge, sampled at the rising edge
// Notes: released address/data lines are inverted, so nothing stale reads as valid
`timescale 1ns/1ns
module host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic reg_sel_o,
  output logic legacy_o,
  output logic [11:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o
);
  initial begin
    reg_sel_o = 1'h0;
    legacy_o = 1'h0;
    addr_o = 12'h000;
    wr_o = 1'h0;
    rd_o = 1'h0;
    wdata_o = 8'h00;
  end
  task automatic wr(input logic lg, input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {reg_sel_o, legacy_o, addr_o, wdata_o, wr_o} = {1'h1, lg, a, d, 1'h1};
    @(negedge clk_i);
    {reg_sel_o, wr_o, addr_o, wdata_o} = {1'h0, 1'h0, ~a, ~d};
  endtask
  // read data is taken one cycle after the strobe
  task automatic rd(input logic lg, input logic [11:0] a, output logic [7:0] q);
    @(negedge clk_i);
    {reg_sel_o, legacy_o, addr_o, rd_o} = {1'h1, lg, a, 1'h1};
    @(negedge clk_i);
    {reg_sel_o, rd_o, addr_o} = {1'h0, 1'h0, ~a};
    q = rdata_i;
  endtask
endmodule // host_model

/* sim/tb.sv */
// Purpose: self-checking bench for the socket register bank
// Assumes: inputs change at the falling edge
// Notes: table rows first, reset and mode cases by hand
`timescale 1ns/1ns
module tb;
  import sockreg_pkg::*;
  typedef struct {logic lg; logic [11:0] a; byte_t d; byte_t e;} row_s;
  logic clk_i = 1'h0, rst_i = 1'h1, global_reset_in = 1'h1, cyc = 1'h0, pa = 1'h0, pb = 1'h0;
  logic csc_rd = 1'h0, csc_wr = 1'h0, cd_set = 1'h0, ev_a = 1'h0, ev_b = 1'h0;
  logic sel, lg, wr, rd, sw_cd, ia, ib, ic, oe, acc;
  logic [11:0] addr;
  logic [15:0] w0, w1;
  byte_t wd, rdat, q, scr, csc_ev = 8'h00, cwd = 8'h08;
  int mismatches = 0, n_compared = 0;
  // unmapped row last: must read zero
  row_s rows[7] = '{'{1'h0, 12'h81E, 8'hFF, 8'h1F}, '{1'h1, 12'h01E, 8'h0A, 8'h0A},
    '{1'h0, 12'h836, 8'hFF, 8'hFE}, '{1'h0, 12'h837, 8'hA5, 8'hA5}, '{1'h0, 12'h838, 8'h31, 8'h30},
    '{1'h0, 12'h839, 8'h5A, 8'h5A}, '{1'h0, 12'h83A, 8'h77, 8'h00}};
  always #2 clk_i = ~clk_i;
  host_model host (.clk_i(clk_i), .rdata_i(rdat), .reg_sel_o(sel), .legacy_o(lg), .addr_o(addr),
    .wr_o(wr), .rd_o(rd), .wdata_o(wd));
  socket_regs dut (.clk_i(clk_i), .rst_i(rst_i), .global_reset_in_i(global_reset_in), .reg_sel_i(sel),
    .legacy_i(lg), .addr_i(addr), .wr_i(wr), .rd_i(rd), .wdata_i(wd), .rdata_o(rdat),
    .csc_rd_i(csc_rd), .csc_wr_i(csc_wr), .csc_wdata_i(cwd), .csc_event_i(csc_ev),
    .sw_cd_req_set_i(cd_set), .sw_cd_req_o(sw_cd), .status_change_reg_o(scr),
    .card_a_event_i(ev_a), .card_b_event_i(ev_b), .card_a_pending_i(pa), .card_b_pending_i(pb),
    .irq_a_o(ia), .irq_b_o(ib), .irq_csc_o(ic), .card_cycle_i(cyc), .card_out_en_o(oe),
    .card_irq_accept_o(acc), .win0_offset_o(w0), .win1_offset_o(w1));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic csc_op(input byte_t ev, input logic r, input logic w, input logic s);
    @(negedge clk_i);
    {csc_ev, csc_rd, csc_wr, cd_set} = {ev, r, w, s};
    @(negedge clk_i);
    {csc_ev, csc_rd, csc_wr, cd_set} = {8'h00, 3'h0};
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    {rst_i, global_reset_in} = 2'h0;
    foreach (rows[i]) begin
      host.wr(rows[i].lg, rows[i].a, rows[i].d);
      host.rd(rows[i].lg, rows[i].a, q);
      chk("reg", {8'h00, rows[i].e}, {8'h00, q});
    end
    chk("win0", 16'hA5FE, w0);
    chk("win1", 16'h5A30, w1);
    $display("table test done");
    host.wr(1'h0, 12'h81E, 8'h1F);
    @(negedge clk_i) rst_i = 1'h1;
    @(negedge clk_i) rst_i = 1'h0;
    host.rd(1'h0, 12'h81E, q);
    chk("soft reset", 16'h0007, {8'h00, q});
    @(negedge clk_i) global_reset_in = 1'h1;
    @(negedge clk_i) global_reset_in = 1'h0;
    host.rd(1'h0, 12'h81E, q);
    chk("global reset", 16'h0000, {8'h00, q});
    host.rd(1'h0, 12'h839, q);
    chk("high reset", 16'h0000, {8'h00, q});
    $display("reset test done");
    host.wr(1'h0, 12'h81E, 8'h01);
    chk("oe idle", 16'h0000, {15'h0000, oe});
    cyc = 1'h1;
    #1 chk("oe cycle", 16'h0001, {15'h0000, oe});
    @(negedge clk_i) cyc = 1'h0;
    #1 chk("oe after", 16'h0000, {15'h0000, oe});
    chk("irq accept", 16'h0001, {15'h0000, acc});
    $display("power-down test done");
    // pending held high in edge mode must not hold the line
    host.wr(1'h0, 12'h81E, 8'h00);
    {pa, pb, ev_a, ev_b} = 4'hF;
    @(negedge clk_i) {ev_a, ev_b} = 2'h0;
    chk("edge pulse", 16'h0003, {14'h0000, ia, ib});
    @(negedge clk_i);
    chk("edge end", 16'h0000, {14'h0000, ia, ib});
    // level mode with power-down on: interrupts must still reach the host
    host.wr(1'h0, 12'h81E, 8'h19);
    repeat (2) @(negedge clk_i);
    chk("level hold", 16'h0003, {14'h0000, ia, ib});
    {pa, pb} = 2'h0;
    #1 chk("level drop", 16'h0000, {14'h0000, ia, ib});
    $display("irq test done");
    csc_op(8'h08, 1'h0, 1'h0, 1'h0);
    chk("csc edge", 16'h0001, {15'h0000, ic});
    csc_op(8'h00, 1'h0, 1'h1, 1'h0);
    chk("wb ignored", 16'h0008, {7'h00, ic, scr});
    csc_op(8'h00, 1'h1, 1'h0, 1'h0);
    chk("read clear", 16'h0000, {8'h00, scr});
    host.wr(1'h0, 12'h81E, 8'h06);
    csc_op(8'h08, 1'h1, 1'h0, 1'h1);
    csc_op(8'h00, 1'h1, 1'h0, 1'h0);
    chk("read kept", 16'h0308, {6'h00, ic, sw_cd, scr});
    // write-one to another flag leaves card-detect and its request alone
    cwd = 8'h01;
    csc_op(8'h00, 1'h0, 1'h1, 1'h0);
    chk("wb other", 16'h0308, {6'h00, ic, sw_cd, scr});
    cwd = 8'h08;
    csc_op(8'h08, 1'h0, 1'h1, 1'h0);
    chk("set wins", 16'h0208, {6'h00, ic, sw_cd, scr});
    csc_op(8'h00, 1'h0, 1'h1, 1'h0);
    chk("wb clear", 16'h0000, {6'h00, ic, sw_cd, scr});
    $display("flag clear test done");
    conclude();
  end
  // run is under a hundred cycles
  initial begin
    #8000;
    mismatches++;
    conclude();
  end
endmodule // tb
